// file: pkg/twwd_regs.svh
`ifndef TWWD_REGS_SVH
`define TWWD_REGS_SVH

// clock period and timing figures
`define TWWD_CLK_NS         4
`define TWWD_FAST_STEP_NS   8000
`define TWWD_SLOW_STEP_NS   64000
`define TWWD_FAST_STEP_CYC  (`TWWD_FAST_STEP_NS / `TWWD_CLK_NS)
`define TWWD_RST_STATE_NS   1000000
`define TWWD_RST_PULSE_NS   200000
`define TWWD_STARTUP_MS     500

// key codes, limits and reset values
`define TWWD_KEY_A          2'h1
`define TWWD_KEY_B          2'h2
`define TWWD_TIMER_MAX      8'hff
`define TWWD_WIN_MIN_RST    8'h40
`define TWWD_WIN_DELTA_RST  8'h40
`define TWWD_RETRY_TH_RST   4'h3
`define TWWD_RETRY_MAX      4'hf

`endif

// file: pkg/twwd_pkg.sv
package twwd_pkg;

    typedef enum logic [2:0] {
        TWWD_INITIAL,
        TWWD_RUN,
        TWWD_TEST,
        TWWD_TIMED_RESET,
        TWWD_OVERRIDE
    } twwd_state_type;

    typedef struct packed {
        twwd_state_type st;
        logic [26:0]    dwell;
        logic [7:0]     timer;
        logic           key_a_seen;
        logic           key_b_seen;
        logic           tovr;
        logic           frozen;
        logic           fast;
        logic [7:0]     win_min;
        logic [7:0]     win_delta;
        logic [3:0]     retry_cnt;
        logic [3:0]     retry_th;
        logic           th_lock;
        logic           wdr;
        logic           lockout;
        logic           refresh;
        logic           violation;
        logic           tm;
        logic           arm_en;
        logic           rst_pin_n;
        logic           dis_state;
        logic           ovr_act;
    } twwd_core_type;

endpackage

// file: pkg/twwd_step_if.sv
`timescale 1ns/100ps
`default_nettype none

interface twwd_step_if;
    logic clear;
    logic fast;
    logic step;
    modport ctrl (output clear, output fast, input step);
    modport gen  (input clear, input fast, output step);
endinterface

`default_nettype wire

// file: hdl/twwd_sync.sv
`timescale 1ns/100ps
`default_nettype none

module twwd_sync #(
    parameter int W = 2
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] d_i,
    output var  logic [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } twwd_sync_state_type;

    twwd_sync_state_type r;
    twwd_sync_state_type next_r;

    // first stage feeds only the second
    always_comb begin
        next_r.s1 = d_i;
        next_r.s2 = r.s1;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign q_o = r.s2;
endmodule

`default_nettype wire

// file: hdl/twwd_tick.sv
`timescale 1ns/100ps
`default_nettype none
`include "twwd_regs.svh"

module twwd_tick #(
    parameter int SLOW_STEP_CYC = `TWWD_SLOW_STEP_NS / `TWWD_CLK_NS
) (
    input  wire logic  clk_i,
    input  wire logic  rst_i,
    twwd_step_if.gen   bus
);
    typedef struct packed {
        logic [13:0] div;
        logic        step;
    } twwd_tick_state_type;

    twwd_tick_state_type r;
    twwd_tick_state_type next_r;
    logic [13:0]         lim;

    // 8 us or 64 us window steps
    always_comb begin
        lim = bus.fast ? 14'(`TWWD_FAST_STEP_CYC - 1) : 14'(SLOW_STEP_CYC - 1);
        next_r = r;
        next_r.step = 1'b0;
        if (bus.clear) begin
            next_r.div = 14'h0;
        end else if (r.div >= lim) begin
            next_r.div = 14'h0;
            next_r.step = 1'b1;
        end else begin
            next_r.div = r.div + 14'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign bus.step = r.step;
endmodule

`default_nettype wire

// file: hdl/twwd_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "twwd_regs.svh"

// Notes on behaviour
// - mistimed service raises error and fault flag
// - initial state: no service, arming disabled
// - run state demands window-timed service
// - test state: no deploy, no lockout, flagged
// - error enters reset state for 1 ms
// - override state: no supervision, acts as run
// - machine reset returns initial, clears status
// - refresh accepted on A-B or B-A in window
// - qualified error sets latched reset flag
// - lockout latches, readable, blocks arming
// - test command: run->test, initial->override if pin
// - errors in initial and run counted in retry counter
// - retry threshold writable by host
// - threshold write blocked after run entry
// - fast 8 us steps, slow 64 us steps
// - configuration only in Init, frozen at Diag
// - override bit allows indefinite initial state
// - correct key outside window is an error
// - wrong key never raises an error
// - key pair clears timer; timer readable
// - reset pin pulsed, faults kept
// - disable pin readable, holds timer at zero, no faults
module twwd_top #(
    parameter int SLOW_STEP_CYC = `TWWD_SLOW_STEP_NS / `TWWD_CLK_NS,
    parameter int RST_STATE_CYC = `TWWD_RST_STATE_NS / `TWWD_CLK_NS,
    parameter int RST_PULSE_CYC = `TWWD_RST_PULSE_NS / `TWWD_CLK_NS,
    parameter int STARTUP_CYC   = `TWWD_STARTUP_MS * 1000000 / `TWWD_CLK_NS
) (
    // clock and reset
    input  wire logic       SYS_CLK_I,
    input  wire logic       RESET_I,
    input  wire logic       STATE_MACHINE_RESET_I,
    // key service
    input  wire logic       KEY_WRITE_I,
    input  wire logic [1:0] KEY_CODE_I,
    // commands
    input  wire logic       TEST_CMD_I,
    input  wire logic       TIMER_OVERRIDE_I,
    // configuration
    input  wire logic       OPSTATE_INIT_I,
    input  wire logic       DIAG_ENTER_I,
    input  wire logic       CFG_WRITE_I,
    input  wire logic       CFG_FAST_I,
    input  wire logic [7:0] CFG_MIN_I,
    input  wire logic [7:0] CFG_DELTA_I,
    input  wire logic       THRESH_WRITE_I,
    input  wire logic [3:0] THRESH_I,
    // pins
    input  wire logic       DISABLE_PIN_I,
    input  wire logic       TEST_PIN_HIGH_I,
    // status
    output var  logic [7:0] TIMER_VALUE_O,
    output var  logic       REFRESH_ACCEPTED_O,
    output var  logic       WINDOW_VIOLATION_O,
    output var  logic       WD_RESET_FLAG_O,
    output var  logic       TEST_MODE_FLAG_O,
    output var  logic       ARMING_LOCKOUT_O,
    output var  logic       OVERRIDE_ACTIVE_O,
    output var  logic       DISABLE_PIN_STATE_O,
    output var  logic [3:0] RETRY_COUNT_O,
    output var  logic [3:0] RETRY_THRESHOLD_O,
    output var  logic       THRESHOLD_LOCK_O,
    output var  logic       CONFIG_FROZEN_O,
    // arming and reset pin
    output var  logic       ARM_ENABLE_O,
    output var  logic       RESET_PIN_N_O
);

    ////////////////////////////////////////////////////////////////////////////

    localparam twwd_pkg::twwd_core_type CORE_RST = '{
        st:        twwd_pkg::TWWD_INITIAL,
        win_min:   `TWWD_WIN_MIN_RST,
        win_delta: `TWWD_WIN_DELTA_RST,
        retry_th:  `TWWD_RETRY_TH_RST,
        rst_pin_n: 1'b1,
        default:   '0
    };

    twwd_pkg::twwd_core_type r;
    twwd_pkg::twwd_core_type next_r;
    twwd_pkg::twwd_core_type sm;

    logic [1:0] pins_s;
    logic       dis_s;
    logic       tpin_s;
    logic       key_ab;
    logic       key_valid;
    logic       pair_done;
    logic [8:0] win_end;
    logic       in_win;
    logic       late;
    logic       err;
    logic       err_count;
    logic       tmr_clr;

    twwd_step_if step_bus ();

    ////////////////////////////////////////////////////////////////////////////

    // both pins arrive from outside the clock domain
    twwd_sync #(
        .W (2)
    ) u_sync (
        .clk_i (SYS_CLK_I),
        .rst_i (RESET_I),
        .d_i   ({DISABLE_PIN_I, TEST_PIN_HIGH_I}),
        .q_o   (pins_s)
    );

    assign dis_s  = pins_s[1];
    assign tpin_s = pins_s[0];

    twwd_tick #(
        .SLOW_STEP_CYC (SLOW_STEP_CYC)
    ) u_tick (
        .clk_i (SYS_CLK_I),
        .rst_i (RESET_I),
        .bus   (step_bus)
    );

    assign step_bus.fast  = r.fast;
    assign step_bus.clear = tmr_clr;

    ////////////////////////////////////////////////////////////////////////////

    function automatic logic [3:0] sat_inc(input logic [3:0] v);
        sat_inc = (v == `TWWD_RETRY_MAX) ? v : v + 4'h1;
    endfunction

    always_comb begin
        next_r = r;
        sm = CORE_RST;
        err = 1'b0;
        err_count = 1'b0;
        tmr_clr = 1'b0;
        next_r.refresh = 1'b0;
        next_r.violation = 1'b0;

        // any other code is a wrong key and is simply ignored
        key_ab = (KEY_CODE_I == `TWWD_KEY_A) || (KEY_CODE_I == `TWWD_KEY_B);
        key_valid = KEY_WRITE_I && key_ab;
        // second key must be the other one, either order
        pair_done = key_valid &&
                    (((KEY_CODE_I == `TWWD_KEY_A) && r.key_b_seen) ||
                     ((KEY_CODE_I == `TWWD_KEY_B) && r.key_a_seen));
        win_end = {1'b0, r.win_min} + {1'b0, r.win_delta};
        in_win = (r.timer >= r.win_min) && ({1'b0, r.timer} < win_end);
        // saturated timer also counts as late
        late = ({1'b0, r.timer} >= win_end) || (r.timer == `TWWD_TIMER_MAX);

        // config writes only in Init, frozen from Diag on
        if (CFG_WRITE_I && OPSTATE_INIT_I && !r.frozen) begin
            next_r.fast = CFG_FAST_I;
            next_r.win_min = CFG_MIN_I;
            next_r.win_delta = CFG_DELTA_I;
        end
        if (DIAG_ENTER_I) begin
            next_r.frozen = 1'b1;
        end
        // host chooses the tolerated error count
        if (THRESH_WRITE_I && !r.th_lock) begin
            next_r.retry_th = THRESH_I;
        end

        unique case (r.st)
            twwd_pkg::TWWD_INITIAL: begin
                if (TIMER_OVERRIDE_I) begin
                    next_r.tovr = 1'b1;
                end
                if (TEST_CMD_I && tpin_s) begin
                    next_r.st = twwd_pkg::TWWD_OVERRIDE;
                end else if (pair_done) begin
                    next_r.st = twwd_pkg::TWWD_RUN;
                    next_r.th_lock = 1'b1;
                    next_r.refresh = 1'b1;
                end else if (!r.tovr && !TIMER_OVERRIDE_I && !dis_s &&
                             r.dwell == 27'(STARTUP_CYC - 1)) begin
                    // host silent past the startup interval
                    err = 1'b1;
                    err_count = 1'b1;
                end
            end
            twwd_pkg::TWWD_RUN: begin
                if (TEST_CMD_I) begin
                    next_r.st = twwd_pkg::TWWD_TEST;
                end else if (dis_s) begin
                    err = 1'b0;
                end else if (key_valid && !in_win) begin
                    err = 1'b1;
                    err_count = 1'b1;
                end else if (pair_done) begin
                    next_r.refresh = 1'b1;
                end else if (late) begin
                    err = 1'b1;
                    err_count = 1'b1;
                end
            end
            twwd_pkg::TWWD_TEST: begin
                // same check as run, but errors neither count nor lock
                if (dis_s) begin
                    err = 1'b0;
                end else if (key_valid && !in_win) begin
                    err = 1'b1;
                end else if (pair_done) begin
                    next_r.refresh = 1'b1;
                    next_r.st = twwd_pkg::TWWD_RUN;
                end else if (late) begin
                    err = 1'b1;
                end
            end
            twwd_pkg::TWWD_TIMED_RESET: begin
                if (r.dwell == 27'(RST_STATE_CYC - 1)) begin
                    next_r.st = twwd_pkg::TWWD_INITIAL;
                    if (r.retry_cnt >= r.retry_th) begin
                        next_r.lockout = 1'b1;
                    end
                end
            end
            twwd_pkg::TWWD_OVERRIDE: begin
                // supervision off; arming behaves as in run
                next_r.st = twwd_pkg::TWWD_OVERRIDE;
            end
        endcase

        if (err) begin
            next_r.st = twwd_pkg::TWWD_TIMED_RESET;
            next_r.violation = 1'b1;
            next_r.wdr = 1'b1;
        end
        if (err_count) begin
            next_r.retry_cnt = sat_inc(r.retry_cnt);
        end

        // dwell times startup and the reset state; restarts per state
        if (next_r.st != r.st) begin
            next_r.dwell = 27'h0;
        end else if (dis_s && r.st == twwd_pkg::TWWD_INITIAL) begin
            next_r.dwell = 27'h0;
        end else if (r.dwell != 27'h7ffffff) begin
            next_r.dwell = r.dwell + 27'h1;
        end

        // key memory restarts after a pair or a state change
        if (pair_done || next_r.st != r.st) begin
            next_r.key_a_seen = 1'b0;
            next_r.key_b_seen = 1'b0;
        end else if (key_valid) begin
            next_r.key_a_seen = r.key_a_seen || (KEY_CODE_I == `TWWD_KEY_A);
            next_r.key_b_seen = r.key_b_seen || (KEY_CODE_I == `TWWD_KEY_B);
        end

        // window timer runs only while service is demanded
        if (!(next_r.st inside {twwd_pkg::TWWD_RUN, twwd_pkg::TWWD_TEST}) ||
            dis_s || pair_done || next_r.st != r.st) begin
            next_r.timer = 8'h0;
            tmr_clr = 1'b1;
        end else if (step_bus.step && r.timer != `TWWD_TIMER_MAX) begin
            next_r.timer = r.timer + 8'h1;
        end

        // machine reset keeps configuration, clears all status
        if (STATE_MACHINE_RESET_I) begin
            sm.fast = next_r.fast;
            sm.win_min = next_r.win_min;
            sm.win_delta = next_r.win_delta;
            sm.frozen = next_r.frozen;
            sm.retry_th = next_r.retry_th;
            next_r = sm;
            tmr_clr = 1'b1;
        end

        // registered views of the state
        next_r.tm = (next_r.st == twwd_pkg::TWWD_TEST);
        next_r.ovr_act = (next_r.st == twwd_pkg::TWWD_OVERRIDE);
        // arming only in run or override, never under lockout
        next_r.arm_en = (next_r.st inside {twwd_pkg::TWWD_RUN, twwd_pkg::TWWD_OVERRIDE}) &&
                        !next_r.lockout;
        // reset pin low from reset-state entry; flags are left alone
        next_r.rst_pin_n = !((next_r.st == twwd_pkg::TWWD_TIMED_RESET) &&
                             (next_r.dwell < 27'(RST_PULSE_CYC)));
        next_r.dis_state = dis_s;
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            r <= CORE_RST;
        end else begin
            r <= next_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    assign TIMER_VALUE_O       = r.timer;
    assign REFRESH_ACCEPTED_O  = r.refresh;
    assign WINDOW_VIOLATION_O  = r.violation;
    assign WD_RESET_FLAG_O     = r.wdr;
    assign TEST_MODE_FLAG_O    = r.tm;
    assign ARMING_LOCKOUT_O    = r.lockout;
    assign OVERRIDE_ACTIVE_O   = r.ovr_act;
    assign DISABLE_PIN_STATE_O = r.dis_state;
    assign RETRY_COUNT_O       = r.retry_cnt;
    assign RETRY_THRESHOLD_O   = r.retry_th;
    assign THRESHOLD_LOCK_O    = r.th_lock;
    assign CONFIG_FROZEN_O     = r.frozen;
    assign ARM_ENABLE_O        = r.arm_en;
    assign RESET_PIN_N_O       = r.rst_pin_n;

    ////////////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (RESET_I);

    localparam int RST_LAST = RST_STATE_CYC - 1;

    chk_no_arm_states: assert property (
        r.st inside {twwd_pkg::TWWD_INITIAL, twwd_pkg::TWWD_TEST, twwd_pkg::TWWD_TIMED_RESET}
        |-> !ARM_ENABLE_O)
        else $error("arming enabled in a safe state");

    chk_lockout_sticky: assert property (
        ARMING_LOCKOUT_O && !STATE_MACHINE_RESET_I |=> ARMING_LOCKOUT_O && !ARM_ENABLE_O)
        else $error("lockout dropped or arming enabled");

    chk_reset_exit: assert property (
        r.st == twwd_pkg::TWWD_TIMED_RESET && r.dwell == 27'(RST_LAST) && !STATE_MACHINE_RESET_I
        |=> r.st == twwd_pkg::TWWD_INITIAL)
        else $error("reset state did not end after 1 ms");

    chk_reset_bound: assert property (
        r.st == twwd_pkg::TWWD_TIMED_RESET |-> r.dwell <= 27'(RST_LAST))
        else $error("reset state too long");

    chk_early_key_err: assert property (
        r.st == twwd_pkg::TWWD_RUN && KEY_WRITE_I && key_ab && !in_win && !dis_s &&
        !TEST_CMD_I && !STATE_MACHINE_RESET_I
        |=> WINDOW_VIOLATION_O && WD_RESET_FLAG_O && !RESET_PIN_N_O)
        else $error("mistimed key not flagged");

    chk_wrong_key_quiet: assert property (
        r.st == twwd_pkg::TWWD_RUN && KEY_WRITE_I && !key_ab && !late |=> !WINDOW_VIOLATION_O)
        else $error("wrong key raised an error");

    chk_test_no_count: assert property (
        r.st == twwd_pkg::TWWD_TEST && !STATE_MACHINE_RESET_I
        |=> RETRY_COUNT_O == $past(RETRY_COUNT_O) && ARMING_LOCKOUT_O == $past(ARMING_LOCKOUT_O))
        else $error("test state counted an error");

    chk_smr_clears: assert property (
        STATE_MACHINE_RESET_I |=> r.st == twwd_pkg::TWWD_INITIAL && !WD_RESET_FLAG_O &&
        !ARMING_LOCKOUT_O && !TEST_MODE_FLAG_O && RETRY_COUNT_O == 4'h0)
        else $error("machine reset left status set");

    chk_th_locked: assert property (
        THRESHOLD_LOCK_O && THRESH_WRITE_I |=> RETRY_THRESHOLD_O == $past(RETRY_THRESHOLD_O))
        else $error("threshold written after run entry");

    chk_disable_hold: assert property (
        dis_s |=> TIMER_VALUE_O == 8'h0 && !WINDOW_VIOLATION_O)
        else $error("disabled timer moved or faulted");

    chk_test_entry: assert property (
        r.st == twwd_pkg::TWWD_RUN && TEST_CMD_I && !STATE_MACHINE_RESET_I
        |=> TEST_MODE_FLAG_O ##1 (r.st != twwd_pkg::TWWD_INITIAL || $past(STATE_MACHINE_RESET_I)))
        else $error("test command ignored in run");

    cov_test:     cover property (TEST_MODE_FLAG_O ##1 REFRESH_ACCEPTED_O);
    cov_override: cover property (r.st == twwd_pkg::TWWD_OVERRIDE);
    cov_lockout:  cover property ($rose(ARMING_LOCKOUT_O));
    cov_refresh:  cover property (r.st == twwd_pkg::TWWD_RUN && REFRESH_ACCEPTED_O);

endmodule

`default_nettype wire

// file: dv/twwd_host.sv
`timescale 1ns/100ps
`default_nettype none

module twwd_host (
    // clock
    input  wire logic       clk_i,
    // key service
    output var  logic       key_write_o,
    output var  logic [1:0] key_code_o
);
    initial begin
        key_write_o = 1'b0;
        key_code_o  = 2'h0;
    end

    ////////////////////////////////////////////////////////////////////////
    // one timer-register write; idle code flips so it is never held
    task automatic key(input logic [1:0] c);
        @(negedge clk_i);
        key_write_o = 1'b1;
        key_code_o  = c;
        @(negedge clk_i);
        key_write_o = 1'b0;
        key_code_o  = ~c;
    endtask
endmodule

`default_nettype wire

// file: dv/twwd_top_tb.sv
`timescale 1ns/100ps
`default_nettype none

module twwd_top_tb;
    logic       clk  = 1'b0;
    logic       rst  = 1'b1;
    logic       smr  = 1'b0;
    logic       tcmd = 1'b0;
    logic       tovr = 1'b0;
    logic       opst = 1'b1;
    logic       diag = 1'b0;
    logic       cfgw = 1'b0;
    logic [7:0] cmin = 8'h02;
    logic [7:0] cdel = 8'h03;
    logic       thw  = 1'b0;
    logic [3:0] th   = 4'h2;
    logic       dis  = 1'b0;
    logic       tpin = 1'b0;
    logic       cfst = 1'b0;
    logic       kw;
    logic [1:0] kc;
    logic [7:0] tv;
    logic       rfa, vio, wdr, tm, lko, ovr, dps, thl, frz, arm, rpn;
    logic [3:0] rc, rth;
    int         bad_count  = 0;
    int         n_compared = 0;

    always #2 clk = ~clk;

    twwd_host host_u (.clk_i(clk), .key_write_o(kw), .key_code_o(kc));

    twwd_top #(.SLOW_STEP_CYC(20), .RST_STATE_CYC(50), .RST_PULSE_CYC(10), .STARTUP_CYC(200)) dut_u (
        .SYS_CLK_I(clk), .RESET_I(rst), .STATE_MACHINE_RESET_I(smr),
        .KEY_WRITE_I(kw), .KEY_CODE_I(kc), .TEST_CMD_I(tcmd), .TIMER_OVERRIDE_I(tovr),
        .OPSTATE_INIT_I(opst), .DIAG_ENTER_I(diag), .CFG_WRITE_I(cfgw), .CFG_FAST_I(cfst),
        .CFG_MIN_I(cmin), .CFG_DELTA_I(cdel), .THRESH_WRITE_I(thw), .THRESH_I(th),
        .DISABLE_PIN_I(dis), .TEST_PIN_HIGH_I(tpin), .TIMER_VALUE_O(tv),
        .REFRESH_ACCEPTED_O(rfa), .WINDOW_VIOLATION_O(vio), .WD_RESET_FLAG_O(wdr),
        .TEST_MODE_FLAG_O(tm), .ARMING_LOCKOUT_O(lko), .OVERRIDE_ACTIVE_O(ovr),
        .DISABLE_PIN_STATE_O(dps), .RETRY_COUNT_O(rc), .RETRY_THRESHOLD_O(rth),
        .THRESHOLD_LOCK_O(thl), .CONFIG_FROZEN_O(frz), .ARM_ENABLE_O(arm), .RESET_PIN_N_O(rpn));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    // one-cycle command pulse; outputs are settled when it returns
    task automatic pulse(ref logic s);
        @(negedge clk);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
    endtask

    task automatic pair(input logic [1:0] a, input logic [1:0] b);
        host_u.key(a);
        host_u.key(b);
    endtask

    task automatic waitt(input logic [7:0] v);
        for (int i = 0; i < 300 && tv !== v; i++) @(negedge clk);
        chk("timer", v, tv);
        if (tv !== v) wrap_up();
    endtask

    // pulse is one cycle wide, so every cycle is looked at
    task automatic waitv(input int lim, input logic want);
        logic g;
        g = 1'b0;
        for (int i = 0; i < lim && !g; i++) begin
            @(negedge clk);
            g = (vio === 1'b1);
        end
        chk("violation", 8'(want), 8'(g));
        if (g !== want) wrap_up();
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        cyc(12);
        rst = 1'b0;
        cyc(1);
        chk("arm", 8'h0, 8'(arm));
        chk("rstpin", 8'h1, 8'(rpn));
        chk("thresh", 8'h3, 8'(rth));
        pulse(cfgw);
        pulse(thw);
        chk("thresh", 8'h2, 8'(rth));
        pulse(diag);
        chk("frozen", 8'h1, 8'(frz));
        cmin = 8'h00;
        cdel = 8'h01;
        pulse(cfgw);
        opst = 1'b0;
        pair(2'h1, 2'h2);
        chk("arm", 8'h1, 8'(arm));
        chk("thlock", 8'h1, 8'(thl));
        th = 4'h5;
        pulse(thw);
        chk("thresh", 8'h2, 8'(rth));
        // blocked write's window of 1 step would make timer 2 late
        waitt(8'h02);
        pair(2'h2, 2'h1);
        chk("refresh", 8'h1, 8'(rfa));
        chk("timer", 8'h00, tv);
        host_u.key(2'h3);
        chk("violation", 8'h0, 8'(vio));
        host_u.key(2'h1);
        chk("violation", 8'h1, 8'(vio));
        chk("wdr", 8'h1, 8'(wdr));
        chk("rstpin", 8'h0, 8'(rpn));
        chk("retry", 8'h1, 8'(rc));
        cyc(8);
        chk("rstpin", 8'h0, 8'(rpn));
        cyc(4);
        chk("rstpin", 8'h1, 8'(rpn));
        cyc(24);
        chk("arm", 8'h0, 8'(arm));
        cyc(26);
        pair(2'h1, 2'h2);
        chk("arm", 8'h1, 8'(arm));
        chk("wdr", 8'h1, 8'(wdr));
        // unserviced run past the late edge, pin held high
        dis = 1'b1;
        cyc(120);
        chk("dispin", 8'h1, 8'(dps));
        chk("timer", 8'h00, tv);
        chk("arm", 8'h1, 8'(arm));
        chk("retry", 8'h1, 8'(rc));
        dis = 1'b0;
        cyc(3);
        pulse(tcmd);
        chk("testflag", 8'h1, 8'(tm));
        chk("arm", 8'h0, 8'(arm));
        waitt(8'h02);
        pair(2'h1, 2'h2);
        chk("refresh", 8'h1, 8'(rfa));
        chk("testflag", 8'h0, 8'(tm));
        pulse(tcmd);
        chk("testflag", 8'h1, 8'(tm));
        waitv(200, 1'b1);
        chk("retry", 8'h1, 8'(rc));
        cyc(60);
        chk("lockout", 8'h0, 8'(lko));
        pair(2'h2, 2'h1);
        waitv(200, 1'b1);
        chk("retry", 8'h2, 8'(rc));
        cyc(60);
        chk("lockout", 8'h1, 8'(lko));
        pair(2'h1, 2'h2);
        chk("arm", 8'h0, 8'(arm));
        pulse(smr);
        chk("lockout", 8'h0, 8'(lko));
        chk("wdr", 8'h0, 8'(wdr));
        chk("thresh", 8'h2, 8'(rth));
        waitv(300, 1'b1);
        cyc(60);
        pulse(tovr);
        waitv(300, 1'b0);
        tpin = 1'b1;
        cyc(4);
        pulse(tcmd);
        chk("override", 8'h1, 8'(ovr));
        chk("arm", 8'h1, 8'(arm));
        dis = 1'b1;
        cyc(4);
        chk("dispin", 8'h1, 8'(dps));
        chk("timer", 8'h00, tv);
        // full reset unfreezes config; fast steps are 2000 cycles
        dis = 1'b0;
        rst = 1'b1;
        cyc(3);
        rst = 1'b0;
        cyc(1);
        chk("frozen", 8'h0, 8'(frz));
        chk("arm", 8'h0, 8'(arm));
        opst = 1'b1;
        cfst = 1'b1;
        cmin = 8'h01;
        cdel = 8'h02;
        pulse(cfgw);
        pair(2'h2, 2'h1);
        cyc(1990);
        chk("arm", 8'h1, 8'(arm));
        chk("timer", 8'h00, tv);
        waitt(8'h01);
        pair(2'h1, 2'h2);
        chk("refresh", 8'h1, 8'(rfa));
        wrap_up();
    end
endmodule

`default_nettype wire
